// ==== rtl/aci_pkg.sv ====
// aci_pkg: constants, types and state codes of the converter command port.
// assumes a 20 MHz system clock and an open-drain two-wire bus outside.
//
// How it works
// RULE1: core clock runs only while converting or addressed
// RULE2: master makes all clocks, start and stop
// RULE3: data falling with clock high means start
// RULE4: data rising with clock high means stop
// RULE5: data changes during high clock are conditions
// RULE6: master starts only on an idle bus
// RULE7: bytes of eight bits plus acknowledge bit
// RULE8: acknowledge holds data low through clock high
// RULE9: last read byte unacknowledged, device releases data
// RULE10: any number of bytes per transfer
// RULE11: repeated start restarts with fresh address byte
// RULE12: works at standard, fast and high-speed rates
// RULE13: address is prefix, two select bits, direction
// RULE14: select bits latched from pins after power-up
// RULE15: direction one reads, zero writes
// RULE16: matching address byte is acknowledged in hardware
// RULE17: every received byte is acknowledged
// RULE18: read data shifted out on master clock
// RULE19: command byte sets config, channel, power-down
// RULE20: power-down field steers reference and converter
// RULE21: command bit four starts a conversion
// RULE22: high-speed read stretches clock until conversion done
// RULE23: stop leaves high-speed mode, repeated start keeps it
// RULE24: mismatched address ignored until next start
// RULE25: result is one byte, most significant first
`default_nettype none
package aci_pkg;

  // ==========================================================
  // timing
  localparam int SYS_CLK_HZ   = 20_000_000;
  localparam int STD_RATE_HZ  = 100_000;
  localparam int FAST_RATE_HZ = 400_000;
  localparam int HS_RATE_HZ   = 3_400_000;
  // shortest bus half period in system cycles, rounded down
  localparam int HS_HALF_CYCLES = SYS_CLK_HZ / (2 * HS_RATE_HZ);
  localparam int DEF_CONV_CYCLES = 8;
  localparam int SEL_SETTLE_CYCLES = 3;

  // ==========================================================
  // address byte layout
  localparam int ADDR_DIR_BIT    = 0;
  localparam int ADDR_SEL_LO_BIT = 1;
  localparam int ADDR_SEL_HI_BIT = 2;
  localparam int ADDR_PFX_LSB    = 3;
  localparam int ADDR_PFX_MSB    = 7;
  // prefix value is arbitrary, set per product by parameter
  localparam logic [4:0] DEF_ADDR_PREFIX = 5'h0B;
  localparam logic [4:0] MASTER_CODE     = 5'h01;
  localparam logic [3:0] BITS_PER_BYTE   = 4'h8;
  localparam logic [3:0] CMD_CHAN_DONE   = 4'h3;

  // ==========================================================
  // command byte layout and power-down codes
  localparam int CMD_CFG_BIT  = 7;
  localparam int CMD_PD_MSB   = 3;
  localparam int CMD_PD_LSB   = 2;
  localparam logic [1:0] PD_BETWEEN = 2'h0;
  localparam logic [1:0] PD_REF_OFF = 2'h1;
  localparam logic [1:0] PD_ADC_OFF = 2'h2;
  localparam logic [1:0] PD_ALL_ON  = 2'h3;
  localparam logic [7:0] RESULT_RESET = 8'h00;

  typedef struct packed {
    logic       input_config_select;
    logic [2:0] channel_select_field;
    logic [1:0] power_down_field;
  } aci_cmd_t;

  localparam aci_cmd_t CMD_RESET = '{1'b0, 3'h0, PD_BETWEEN};

  // synchronised bus lines and conditions
  typedef struct packed {
    logic scl;
    logic sda;
    logic start;
    logic stop;
    logic scl_rise;
    logic scl_fall;
  } aci_bus_ev_t;

  typedef enum logic [2:0] {
    ST_IDLE     = 3'h0,
    ST_ADDR     = 3'h1,
    ST_ADDR_ACK = 3'h3,
    ST_RX       = 3'h2,
    ST_RX_ACK   = 3'h6,
    ST_TX       = 3'h7,
    ST_TX_ACK   = 3'h5,
    ST_SKIP     = 3'h4
  } aci_state_t;

endpackage : aci_pkg
`default_nettype wire

// ==== rtl/aci_line_sync.sv ====
// aci_line_sync: two-stage synchronisers for bus and strap pins, plus
// start, stop and clock edge detection on the bus lines.
// assumes pin 0 is the bus clock and pin 1 the bus data line.
`timescale 1ns/10ps
`default_nettype none
module aci_line_sync
  import aci_pkg::*;
#(
  parameter int W = 4
) (
  input  wire logic         clock_in,
  input  wire logic         srst_in,
  input  wire logic [W-1:0] pins_in,
  output logic      [W-1:0] pins_out,
  output aci_bus_ev_t       ev_out
);

  // ==========================================================
  // synchronisers
  logic [W-1:0] meta;
  logic         prev_scl;
  logic         prev_sda;

  genvar gi;
  generate
    for (gi = 0; gi < W; gi++) begin : g_sync
      // first stage feeds only the second one
      always_ff @(posedge clock_in) begin
        if (srst_in) begin
          meta[gi]     <= 1'b1;
          pins_out[gi] <= 1'b1;
        end else begin
          meta[gi]     <= pins_in[gi];
          pins_out[gi] <= meta[gi];
        end
      end
    end
  endgenerate

  // ==========================================================
  // conditions
  // a third stage gives the previous level for edge detection
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      prev_scl <= 1'b1;
      prev_sda <= 1'b1;
    end else begin
      prev_scl <= pins_out[0];
      prev_sda <= pins_out[1];
    end
  end

  // data edges while the clock stays high are conditions, not data
  always_comb begin
    ev_out.scl      = pins_out[0];
    ev_out.sda      = pins_out[1];
    ev_out.start    = pins_out[0] & prev_scl & prev_sda & ~pins_out[1]; // RULE3 RULE5
    ev_out.stop     = pins_out[0] & prev_scl & ~prev_sda & pins_out[1]; // RULE4 RULE5
    ev_out.scl_rise = pins_out[0] & ~prev_scl;
    ev_out.scl_fall = ~pins_out[0] & prev_scl;
  end

endmodule : aci_line_sync
`default_nettype wire

// ==== rtl/aci_conv_core.sv ====
// aci_conv_core: converter core on the internal oscillator clock.
// assumes the oscillator runs whenever a start toggle is outstanding.
`timescale 1ns/10ps
`default_nettype none
module aci_conv_core
  import aci_pkg::*;
#(
  parameter int CONV_CYCLES = DEF_CONV_CYCLES
) (
  input  wire logic       conv_clk_in,
  input  wire logic       conv_srst_in,
  input  wire logic       start_tgl_in,
  input  wire logic [7:0] adc_code_in,
  output logic      [7:0] result_out,
  output logic            done_tgl_out
);

  localparam int CW = $clog2(CONV_CYCLES + 1);

  logic          start_meta;
  logic          start_sync;
  logic          start_prev;
  logic          running;
  logic [CW-1:0] count;

  // ==========================================================
  // start toggle crossing
  always_ff @(posedge conv_clk_in) begin
    if (conv_srst_in) begin
      start_meta <= 1'b0;
      start_sync <= 1'b0;
      start_prev <= 1'b0;
    end else begin
      start_meta <= start_tgl_in;
      start_sync <= start_meta;
      start_prev <= start_sync;
    end
  end

  // ==========================================================
  // conversion sequence
  // result only changes here, and the port never asks again while
  // busy, so result_out is stable when the done toggle is seen
  always_ff @(posedge conv_clk_in) begin
    if (conv_srst_in) begin
      running      <= 1'b0;
      count        <= '0;
      result_out   <= RESULT_RESET;
      done_tgl_out <= 1'b0;
    end else if (start_sync != start_prev) begin
      running <= 1'b1;
      count   <= CW'(CONV_CYCLES - 1);
    end else if (running) begin
      if (count == '0) begin
        running      <= 1'b0;
        result_out   <= adc_code_in; // RULE25
        done_tgl_out <= ~done_tgl_out;
      end else begin
        count <= count - 1'b1;
      end
    end
  end

endmodule : aci_conv_core
`default_nettype wire

// ==== rtl/aci_slave.sv ====
// aci_slave: two-wire slave command port of an eight-channel converter.
// assumes an external master clocks the bus (bus rates up to 3.4 MHz
// rely on the 20 MHz sampler) and an oscillator on conv_clk_in that
// runs while osc_run_out is high.
`timescale 1ns/10ps
`default_nettype none
module aci_slave
  import aci_pkg::*;
#(
  parameter logic [4:0] ADDR_PREFIX = DEF_ADDR_PREFIX, // arbitrary value
  parameter int         CONV_CYCLES = DEF_CONV_CYCLES
) (
  input  wire logic       clock_in,
  input  wire logic       srst_in,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            scl_out,
  output logic            scl_oe_out,
  output logic            sda_out,
  output logic            sda_oe_out,
  input  wire logic       device_select_hi_in,
  input  wire logic       device_select_lo_in,
  input  wire logic       conv_clk_in,
  input  wire logic       conv_srst_in,
  input  wire logic [7:0] adc_code_in,
  output aci_cmd_t        cmd_out,
  output logic            adc_on_out,
  output logic            ref_on_out,
  output logic            osc_run_out,
  output logic            hs_mode_out
);

  // ==========================================================
  // declarations
  aci_bus_ev_t ev;
  logic [3:0]  pins_s;
  aci_state_t  state;
  logic [7:0]  shreg;
  logic [3:0]  bit_cnt;
  logic        rd_dir;
  logic        mack;
  logic        stretch;
  logic        sda_drv;
  logic [1:0]  dev_sel;
  logic [1:0]  sel_wait;
  logic        sel_taken;
  logic        start_tgl;
  logic        done_meta;
  logic        done_sync;
  logic        done_prev;
  logic        pend;
  logic [7:0]  result;
  logic [7:0]  core_result;
  logic        core_done_tgl;
  logic        busy;
  logic        byte_end;
  logic        addr_hit;
  logic        mcode_hit;
  logic        chan_kick;
  logic        hs_kick;
  logic        fs_kick;
  logic        kick;
  logic        addressed;

  // ==========================================================
  // pin synchronisers and bus conditions
  aci_line_sync #(
    .W (4)
  ) u_sync (
    .clock_in (clock_in),
    .srst_in  (srst_in),
    .pins_in  ({device_select_lo_in, device_select_hi_in, sda_in, scl_in}),
    .pins_out (pins_s),
    .ev_out   (ev)
  );

  // ==========================================================
  // converter core on the oscillator clock
  aci_conv_core #(
    .CONV_CYCLES (CONV_CYCLES)
  ) u_core (
    .conv_clk_in  (conv_clk_in),
    .conv_srst_in (conv_srst_in),
    .start_tgl_in (start_tgl),
    .adc_code_in  (adc_code_in),
    .result_out   (core_result),
    .done_tgl_out (core_done_tgl)
  );

  // ==========================================================
  // select straps
  // straps are caught once, after the synchronisers have settled,
  // so later pin changes do not move the address
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      sel_wait  <= 2'h0;
      sel_taken <= 1'b0;
      dev_sel   <= 2'h0;
    end else if (!sel_taken) begin
      if (sel_wait == 2'(SEL_SETTLE_CYCLES - 1)) begin
        sel_taken <= 1'b1;
        dev_sel   <= pins_s[3:2]; // RULE14
      end else begin
        sel_wait <= sel_wait + 2'h1;
      end
    end
  end

  // ==========================================================
  // byte decode terms
  always_comb begin
    byte_end  = ev.scl_fall && (bit_cnt == BITS_PER_BYTE); // RULE7
    addr_hit  = (shreg[ADDR_PFX_MSB:ADDR_PFX_LSB] == ADDR_PREFIX) &&
                (shreg[ADDR_SEL_HI_BIT] == dev_sel[0]) &&
                (shreg[ADDR_SEL_LO_BIT] == dev_sel[1]); // RULE13 RULE16
    mcode_hit = (state == ST_ADDR) && byte_end && !ev.start && !ev.stop &&
                (shreg[ADDR_PFX_MSB:ADDR_PFX_LSB] == MASTER_CODE);
    chan_kick = (state == ST_RX) && ev.scl_rise &&
                (bit_cnt == CMD_CHAN_DONE) && !ev.start && !ev.stop; // RULE21
    hs_kick   = (state == ST_ADDR_ACK) && ev.scl_fall && rd_dir &&
                hs_mode_out && !ev.start && !ev.stop; // RULE22
    fs_kick   = (state == ST_TX_ACK) && ev.scl_rise && !ev.sda &&
                !ev.start && !ev.stop;
    kick      = chan_kick || hs_kick || fs_kick;
    addressed = (state != ST_IDLE) && (state != ST_ADDR) &&
                (state != ST_SKIP);
  end

  // ==========================================================
  // bus sequencer
  // start and stop win over any bit activity in the same cycle
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      state   <= ST_IDLE;
      shreg   <= 8'h00;
      bit_cnt <= 4'h0;
      rd_dir  <= 1'b0;
      mack    <= 1'b0;
      stretch <= 1'b0;
      sda_drv <= 1'b0;
    end else if (ev.start) begin
      state   <= ST_ADDR; // RULE3 RULE11
      bit_cnt <= 4'h0;
      mack    <= 1'b0;
      stretch <= 1'b0;
      sda_drv <= 1'b0;
    end else if (ev.stop) begin
      state   <= ST_IDLE; // RULE4
      mack    <= 1'b0;
      stretch <= 1'b0;
      sda_drv <= 1'b0;
    end else begin
      unique case (state)
        ST_IDLE, ST_SKIP: begin
          sda_drv <= 1'b0; // RULE24
        end
        ST_ADDR, ST_RX: begin
          if (ev.scl_rise) begin
            shreg   <= {shreg[6:0], ev.sda};
            bit_cnt <= bit_cnt + 4'h1;
          end else if (byte_end) begin
            if (state == ST_RX) begin
              state   <= ST_RX_ACK;
              sda_drv <= 1'b1; // RULE17 RULE10
            end else if (addr_hit) begin
              state   <= ST_ADDR_ACK;
              rd_dir  <= shreg[ADDR_DIR_BIT]; // RULE15
              sda_drv <= 1'b1; // RULE16 RULE8
            end else begin
              state <= ST_SKIP; // RULE24
            end
          end
        end
        ST_ADDR_ACK: begin
          if (ev.scl_fall) begin
            bit_cnt <= 4'h0;
            if (!rd_dir) begin
              state   <= ST_RX;
              sda_drv <= 1'b0;
            end else if (hs_mode_out) begin
              state   <= ST_TX;
              stretch <= 1'b1; // RULE22
              sda_drv <= 1'b0;
            end else begin
              state   <= ST_TX;
              shreg   <= result;
              sda_drv <= ~result[7]; // RULE18 RULE25
            end
          end
        end
        ST_RX_ACK: begin
          if (ev.scl_fall) begin
            state   <= ST_RX;
            bit_cnt <= 4'h0;
            sda_drv <= 1'b0;
          end
        end
        ST_TX: begin
          if (stretch) begin
            if (!busy && !pend) begin
              stretch <= 1'b0;
              shreg   <= result;
              sda_drv <= ~result[7];
            end
          end else if (ev.scl_fall) begin
            bit_cnt <= bit_cnt + 4'h1;
            if (bit_cnt == BITS_PER_BYTE - 4'h1) begin
              state   <= ST_TX_ACK;
              sda_drv <= 1'b0;
            end else begin
              shreg   <= {shreg[6:0], 1'b0};
              sda_drv <= ~shreg[6]; // RULE18
            end
          end
        end
        ST_TX_ACK: begin
          if (ev.scl_rise) begin
            if (ev.sda) begin
              state <= ST_SKIP; // RULE9
            end else begin
              mack <= 1'b1;
            end
          end else if (ev.scl_fall && mack) begin
            mack    <= 1'b0;
            state   <= ST_TX;
            bit_cnt <= 4'h0;
            shreg   <= result;
            sda_drv <= ~result[7];
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // high-speed mode
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      hs_mode_out <= 1'b0;
    end else if (ev.stop) begin
      hs_mode_out <= 1'b0; // RULE23
    end else if (mcode_hit) begin
      hs_mode_out <= 1'b1; // RULE12
    end
  end

  // ==========================================================
  // command register
  // configuration and channel take effect at the fourth bit so the
  // conversion started there already uses them
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      cmd_out <= CMD_RESET;
    end else if (chan_kick) begin
      cmd_out.input_config_select  <= shreg[2]; // RULE19
      cmd_out.channel_select_field <= {shreg[1:0], ev.sda};
    end else if ((state == ST_RX) && byte_end && !ev.start && !ev.stop) begin
      cmd_out.power_down_field <= shreg[CMD_PD_MSB:CMD_PD_LSB]; // RULE19
    end
  end

  // ==========================================================
  // conversion handshake with the core
  // one request in flight; busy lasts until the result is latched
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      done_meta <= 1'b0;
      done_sync <= 1'b0;
      done_prev <= 1'b0;
    end else begin
      done_meta <= core_done_tgl;
      done_sync <= done_meta;
      done_prev <= done_sync;
    end
  end

  assign busy = (start_tgl ^ done_sync) | (done_sync ^ done_prev);

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      start_tgl <= 1'b0;
      pend      <= 1'b0;
    end else if ((kick || pend) && !busy) begin
      start_tgl <= ~start_tgl; // RULE21
      pend      <= 1'b0;
    end else if (kick) begin
      pend <= 1'b1;
    end
  end

  // core result is held still while the toggle is in flight
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      result <= RESULT_RESET;
    end else if (done_sync != done_prev) begin
      result <= core_result;
    end
  end

  // ==========================================================
  // power and oscillator control
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      adc_on_out  <= 1'b0;
      ref_on_out  <= 1'b0;
      osc_run_out <= 1'b0;
    end else begin
      adc_on_out  <= busy || pend || kick ||
                     cmd_out.power_down_field[0]; // RULE20
      ref_on_out  <= cmd_out.power_down_field[1]; // RULE20
      osc_run_out <= busy || pend || kick || addressed; // RULE1
    end
  end

  // ==========================================================
  // open-drain pins: only ever pull low, never drive the clock high
  assign sda_out    = 1'b0;
  assign scl_out    = 1'b0;
  assign sda_oe_out = sda_drv; // RULE8
  assign scl_oe_out = stretch; // RULE2 RULE22

endmodule : aci_slave
`default_nettype wire

// ==== dv/aci_slave_sva.sv ====
// aci_slave_sva: pin-level checks of the converter command port.
// assumes scl_in and sda_in carry the resolved wire levels.
`timescale 1ns/10ps
`default_nettype none
module aci_slave_sva
  import aci_pkg::*;
#(
  parameter int CONV_CYCLES = DEF_CONV_CYCLES
) (
  input wire logic     clock_in,
  input wire logic     srst_in,
  input wire logic     scl_in,
  input wire logic     sda_in,
  input wire logic     scl_out,
  input wire logic     scl_oe_out,
  input wire logic     sda_out,
  input wire logic     sda_oe_out,
  input wire aci_cmd_t cmd_out,
  input wire logic     adc_on_out,
  input wire logic     ref_on_out,
  input wire logic     osc_run_out,
  input wire logic     hs_mode_out
);
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (srst_in);

  // ==========================================================
  // bus pins
  // drive may only move while the clock wire is low
  sda_steady_a: assert property (
    scl_in && $past(scl_in) |-> $stable(sda_oe_out))
    else $error("data drive moved while clock high");
  ack_release_a: assert property (
    $fell(sda_oe_out) && !$fell(scl_oe_out) |-> !scl_in)
    else $error("data released outside clock low");
  open_drain_a: assert property (
    sda_oe_out || scl_oe_out |-> !sda_out && !scl_out)
    else $error("pin driven high");
  master_code_a: assert property (
    $rose(hs_mode_out) |-> !sda_oe_out)
    else $error("master code acknowledged");
  // stretching only in high-speed mode, and never forever
  fs_no_stretch_a: assert property (!hs_mode_out |-> !scl_oe_out)
    else $error("clock stretched outside high-speed");
  stretch_bound_a: assert property (
    $rose(scl_oe_out) |-> ##[1:300] !scl_oe_out)
    else $error("clock stretch never ended");
  stretch_osc_a: assert property (
    $rose(scl_oe_out) |-> ##[0:3] osc_run_out)
    else $error("stretch without oscillator");
  stop_ends_hs_a: assert property (
    $rose(sda_in) && scl_in && $past(scl_in) |-> ##[1:8] !hs_mode_out)
    else $error("stop kept high-speed mode");

  // ==========================================================
  // power controls
  ref_follow_a: assert property (
    $stable(cmd_out) |-> ref_on_out == cmd_out.power_down_field[1])
    else $error("reference state wrong");
  adc_held_a: assert property (
    $stable(cmd_out) && cmd_out.power_down_field[0] |-> adc_on_out)
    else $error("converter off while held on");

  cover property ($rose(hs_mode_out));
  cover property ($rose(scl_oe_out));
  cover property ($rose(sda_oe_out) && !hs_mode_out);
endmodule : aci_slave_sva

bind aci_slave aci_slave_sva #(.CONV_CYCLES(CONV_CYCLES)) u_aci_slave_sva (
  .clock_in(clock_in), .srst_in(srst_in), .scl_in(scl_in),
  .sda_in(sda_in), .scl_out(scl_out), .scl_oe_out(scl_oe_out),
  .sda_out(sda_out), .sda_oe_out(sda_oe_out), .cmd_out(cmd_out),
  .adc_on_out(adc_on_out), .ref_on_out(ref_on_out),
  .osc_run_out(osc_run_out), .hs_mode_out(hs_mode_out));
`default_nettype wire

// ==== dv/aci_master.sv ====
// aci_master: behavioural two-wire bus master, open drain.
// assumes pull-ups on both wires; tasks are called from the bench.
`timescale 1ns/10ps
`default_nettype none
module aci_master (
  input  wire logic clock_in,
  input  wire logic scl_in,
  input  wire logic sda_in,
  output logic      scl_oe_out,
  output logic      sda_oe_out,
  output logic      hang_out
);
  initial begin
    scl_oe_out = 1'b0;
    sda_oe_out = 1'b0;
    hang_out   = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clock_in);
  endtask : tick

  // release clock; a stretching slave may hold it, so wait bounded
  task automatic scl_high();
    int n;
    n = 0;
    scl_oe_out <= 1'b0;
    @(posedge clock_in);
    while (scl_in !== 1'b1 && n < 400) begin
      @(posedge clock_in);
      n++;
    end
    if (n >= 400) hang_out <= 1'b1;
    tick(4);
  endtask : scl_high

  // 8 low cycles per bit leave room for the slave's sampling lag
  task automatic bit_io(input logic b, output logic got);
    sda_oe_out <= ~b;
    tick(4);
    scl_high();
    got = sda_in;
    scl_oe_out <= 1'b1;
    tick(4);
  endtask : bit_io

  task automatic xfer(input logic [7:0] d, input logic ack_in,
                      output logic [7:0] q, output logic ack_out);
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(ack_in, ack_out);
  endtask : xfer

  // works from idle and as a repeated start
  task automatic start();
    sda_oe_out <= 1'b0;
    tick(4);
    scl_high();
    sda_oe_out <= 1'b1;
    tick(4);
    scl_oe_out <= 1'b1;
    tick(4);
  endtask : start

  task automatic stop();
    sda_oe_out <= 1'b1;
    tick(4);
    scl_high();
    sda_oe_out <= 1'b0;
    tick(8);
  endtask : stop
endmodule : aci_master
`default_nettype wire

// ==== dv/tb_top.sv ====
// tb_top: self-checking bench of the converter command port.
// assumes aci_master on the bus and a gated 6 ns oscillator.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import aci_pkg::*;
  localparam logic [4:0] PFX = 5'h0D; // arbitrary prefix
  logic       clock_in, srst_in, conv_clk, conv_srst, conv_hold;
  logic       sel_hi, sel_lo, scl_w, sda_w, m_scl_oe, m_sda_oe, m_hang;
  logic       scl_out, scl_oe, sda_out, sda_oe;
  logic       adc_on, ref_on, osc_run, hs_mode;
  logic [7:0] adc_code;
  aci_cmd_t   cmd;
  int         failures, total_checks;

  // ==========================================================
  // clocks and wires
  initial begin
    clock_in = 1'b0;
    forever #25 clock_in = ~clock_in;
  end
  // oscillator stands still unless the port's osc_run or the bench's conv_hold asks for it
  initial begin
    conv_clk = 1'b0;
    #1.3;
    forever #3 conv_clk = (osc_run | conv_hold) ? ~conv_clk : 1'b0;
  end
  assign scl_w = ~(m_scl_oe | (scl_oe & ~scl_out));
  assign sda_w = ~(m_sda_oe | (sda_oe & ~sda_out));

  aci_slave #(.ADDR_PREFIX(PFX), .CONV_CYCLES(2)) u_aci_slave (
    .clock_in(clock_in), .srst_in(srst_in), .scl_in(scl_w),
    .sda_in(sda_w), .scl_out(scl_out), .scl_oe_out(scl_oe),
    .sda_out(sda_out), .sda_oe_out(sda_oe),
    .device_select_hi_in(sel_hi), .device_select_lo_in(sel_lo),
    .conv_clk_in(conv_clk), .conv_srst_in(conv_srst),
    .adc_code_in(adc_code), .cmd_out(cmd), .adc_on_out(adc_on),
    .ref_on_out(ref_on), .osc_run_out(osc_run), .hs_mode_out(hs_mode));
  aci_master u_aci_master (
    .clock_in(clock_in), .scl_in(scl_w), .sda_in(sda_w),
    .scl_oe_out(m_scl_oe), .sda_oe_out(m_sda_oe), .hang_out(m_hang));

  // ==========================================================
  // helpers
  task automatic results();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : results

  task automatic check(input logic ok, input string msg);
    total_checks++;
    if (ok !== 1'b1 || m_hang !== 1'b0) begin
      failures++;
      $display("BAD %0t %s", $time, msg);
    end
    if (m_hang !== 1'b0) results();
  endtask : check

  function automatic logic [7:0] adr(input logic rd);
    return {PFX, 1'b1, 1'b0, rd};
  endfunction : adr

  // ==========================================================
  // scenarios
  task automatic t_write();
    logic [7:0] q, cmds [4];
    logic       a;
    int         n;
    cmds = '{8'hD7, 8'h2A, 8'h6E, 8'hB1};
    u_aci_master.start();
    u_aci_master.xfer(adr(1'b0), 1'b1, q, a);
    check(a === 1'b0, "write address not acked");
    for (int i = 0; i < 4; i++) begin
      u_aci_master.xfer(cmds[i], 1'b1, q, a);
      check(a === 1'b0 && cmd === aci_cmd_t'(cmds[i][7:2]), "cmd");
      check(ref_on === cmds[i][3], "reference");
    end
    u_aci_master.stop();
    n = 0;
    while (osc_run !== 1'b0 && n < 200) begin
      @(posedge clock_in);
      n++;
    end
    check(n < 200 && adc_on === 1'b0, "core left on");
    if (n >= 200) results();
  endtask : t_write

  task automatic t_mismatch();
    logic [7:0] q;
    logic       a;
    u_aci_master.start();
    u_aci_master.xfer({PFX, 2'b01, 1'b0}, 1'b1, q, a);
    check(a === 1'b1, "wrong select acked");
    u_aci_master.xfer(8'h00, 1'b1, q, a);
    check(a === 1'b1 && cmd === aci_cmd_t'(6'h2C), "byte taken");
    u_aci_master.start();
    u_aci_master.xfer({~PFX, 2'b10, 1'b0}, 1'b1, q, a);
    check(a === 1'b1, "wrong prefix acked");
    u_aci_master.stop();
  endtask : t_mismatch

  task automatic t_read_fs();
    logic [7:0] q;
    logic       a;
    u_aci_master.start();
    u_aci_master.xfer(adr(1'b1), 1'b1, q, a);
    check(a === 1'b0, "read address not acked");
    u_aci_master.xfer(8'hFF, 1'b0, q, a);
    check(q === 8'hC3, "read data");
    u_aci_master.xfer(8'hFF, 1'b1, q, a);
    check(sda_oe === 1'b0, "data held after nack");
    u_aci_master.xfer(8'hFF, 1'b1, q, a);
    check(q === 8'hFF && a === 1'b1, "read went on after nack");
    u_aci_master.start();
    u_aci_master.xfer(adr(1'b0), 1'b1, q, a);
    check(a === 1'b0, "restart address not acked");
    u_aci_master.stop();
  endtask : t_read_fs

  task automatic t_hs();
    logic [7:0] q;
    logic       a;
    adc_code <= 8'h96;
    u_aci_master.start();
    u_aci_master.xfer(8'h08, 1'b1, q, a);
    check(a === 1'b1 && hs_mode === 1'b1, "master code");
    u_aci_master.start();
    u_aci_master.xfer(adr(1'b1), 1'b1, q, a);
    check(a === 1'b0, "hs read address");
    u_aci_master.xfer(8'hFF, 1'b1, q, a);
    check(q === 8'h96, "hs read data");
    u_aci_master.start();
    check(hs_mode === 1'b1, "restart left hs");
    u_aci_master.stop();
    check(hs_mode === 1'b0, "stop kept hs");
  endtask : t_hs

  // ==========================================================
  // main sequence
  initial begin
    failures = 0;
    total_checks = 0;
    srst_in = 1'b1;
    conv_srst = 1'b1;
    conv_hold = 1'b1;
    sel_hi = 1'b1;
    sel_lo = 1'b0;
    adc_code = 8'hC3;
    repeat (4) @(posedge clock_in);
    check(sda_oe === 1'b0 && scl_oe === 1'b0 && cmd === CMD_RESET &&
          osc_run === 1'b0 && hs_mode === 1'b0, "reset state");
    repeat (4) @(posedge clock_in);
    srst_in <= 1'b0;
    @(posedge conv_clk);
    conv_srst <= 1'b0;
    @(posedge clock_in);
    conv_hold <= 1'b0;
    repeat (8) @(posedge clock_in);
    sel_hi <= 1'b0;
    t_write();
    t_mismatch();
    t_read_fs();
    t_hs();
    results();
  end
endmodule : tb_top
`default_nettype wire
